// File: rtl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  localparam int NUM_GROUPS = 6;
  localparam int NUM_SRC = 12;
  localparam int NUM_LEVELS = 4;
  localparam int LEVEL_W = 2;
  localparam int SRC_W = 4;
  localparam int VEC_W = 16;
  localparam int CALL_CYCLES = 2;
  localparam int STEPS_PER_CYCLE = 6;
  localparam int SAMPLE_STATE = 4;
  // Source index order: group g first member at 2g, second at 2g+1
  localparam logic [SRC_W-1:0] SRC_EXT0 = 4'h0;
  localparam logic [SRC_W-1:0] SRC_ADC = 4'h1;
  localparam logic [SRC_W-1:0] SRC_TIMER0 = 4'h2;
  localparam logic [SRC_W-1:0] SRC_CAN_SW = 4'h3;
  localparam logic [SRC_W-1:0] SRC_EXT1 = 4'h4;
  localparam logic [SRC_W-1:0] SRC_EXT3 = 4'h5;
  localparam logic [SRC_W-1:0] SRC_TIMER1 = 4'h6;
  localparam logic [SRC_W-1:0] SRC_EXT4 = 4'h7;
  localparam logic [SRC_W-1:0] SRC_SERIAL = 4'h8;
  localparam logic [SRC_W-1:0] SRC_EXT5 = 4'h9;
  localparam logic [SRC_W-1:0] SRC_TIMER2 = 4'hA;
  localparam logic [SRC_W-1:0] SRC_EXT6 = 4'hB;
  localparam logic [VEC_W-1:0] VEC_WAKEUP = 16'h007B;
  localparam logic [VEC_W-1:0] VEC_TABLE [NUM_SRC] = '{
    16'h0003, 16'h0043, 16'h000B, 16'h004B, 16'h0013, 16'h0053,
    16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h002B, 16'h006B};
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_CALL1 = 3'b010,
    ST_CALL2 = 3'b100
  } call_state_t;
endpackage

// File: rtl/ext_edge_detect.sv
module ext_edge_detect
  import irq_ctrl_pkg::*;
#(
  parameter bit FALLING = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sample_in,
  input wire logic pin_in,
  output logic edge_out
);
  logic curr;

  // Two successive machine-cycle samples; edge seen on the later one
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      // Idle level of the pin, so no false edge follows reset
      curr <= FALLING;
    end else if (sample_in) begin
      curr <= pin_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      edge_out <= 1'b0;
    end else begin
      edge_out <= sample_in && (FALLING ? (curr && !pin_in)
                                         : (!curr && pin_in));
    end
  end
endmodule

// File: rtl/prio_select.sv
module prio_select
  import irq_ctrl_pkg::*;
(
  input wire logic [NUM_SRC-1:0] req_in,
  input wire logic [NUM_GROUPS-1:0] prio_low_in,
  input wire logic [NUM_GROUPS-1:0] prio_high_in,
  output logic found_out,
  output logic [SRC_W-1:0] src_out,
  output logic [LEVEL_W-1:0] level_out
);
  logic [LEVEL_W-1:0] lvl [NUM_SRC];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_lvl
      assign lvl[gi] = {prio_high_in[gi/2], prio_low_in[gi/2]};
    end
  endgenerate

  // Highest level wins; within level, lowest index is first in poll order
  always_comb begin
    found_out = 1'b0;
    src_out = '0;
    level_out = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (req_in[i] && (!found_out || lvl[i] > level_out)) begin
        found_out = 1'b1;
        src_out = SRC_W'(i);
        level_out = lvl[i];
      end
    end
  end
endmodule

// File: rtl/four_level_interrupt_controller.sv
// Operation
// - Each group's level is its high and low priority bits combined.
// - Six groups pair sources; first member of each pair is polled first.
// - Active routine is preempted only by strictly higher level requests.
// - Top-level routine is never preempted by a source; wake-up ignores levels.
// - Highest level among simultaneous requests is vectored first.
// - Equal levels: lower group number, then first member, wins.
// - Flags sampled at state five phase two, polled one step later in the same cycle.
// - No source call while equal or higher level routine is in progress.
// - Call only when poll meets the last cycle of the instruction.
// - After return or enable/priority write, one more instruction runs.
// - Blocked requests are not remembered; poll sees current samples only.
// - Call loads vector, then pushes program counter, not status word.
// - Each source has a fixed vector address; wake-up uses 007Bh.
// - Return from interrupt ends current level and pops two bytes.
// - Plain return leaves the in-progress state untouched.
// - Ext 0/1: trigger bit 0 low level, 1 falling edge.
// - Ext 0/1 flags cleared on vectoring only in edge mode.
// - Ext 4, 5, 6 flags set only on rising pin transitions.
// - Reload flag set by falling reload pin only with reload enabled.
// - Edge-triggered external flags clear on entering their routine.
// - Call takes two machine cycles; single-level latency 3 to 9.
module four_level_interrupt_controller
  import irq_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] phase_state_in,
  input wire logic insn_last_cycle_in,
  input wire logic insn_is_return_from_interrupt_in,
  input wire logic insn_is_ret_in,
  input wire logic insn_writes_irq_regs_in,
  input wire logic global_enable_in,
  input wire logic [NUM_SRC-1:0] source_enable_in,
  input wire logic [NUM_GROUPS-1:0] priority_low_bits_reg_in,
  input wire logic [NUM_GROUPS-1:0] priority_high_bits_reg_in,
  input wire logic [1:0] ext_trigger_type_bit_in,
  input wire logic [1:0] ext_request_pin_in,
  input wire logic ext_three_pin_in,
  input wire logic ext_three_rising_in,
  input wire logic [2:0] ext_high_pin_in,
  input wire logic reload_trigger_pin_in,
  input wire logic ext_reload_enable_in,
  input wire logic timer0_overflow_in,
  input wire logic timer1_overflow_in,
  input wire logic timer_two_overflow_flag_in,
  input wire logic serial_rx_tx_flags_in,
  input wire logic conversion_done_flag_in,
  input wire logic can_sw_request_in,
  input wire logic wakeup_request_in,
  input wire logic [NUM_SRC-1:0] flag_set_in,
  input wire logic [NUM_SRC-1:0] flag_clear_in,
  input wire logic reload_flag_clear_in,
  input wire logic [VEC_W-1:0] pc_in,
  output logic [NUM_SRC-1:0] flag_out,
  output logic timer_reload_ext_flag_out,
  output logic long_call_out,
  output logic [1:0] call_cycle_out,
  output logic [VEC_W-1:0] vector_out,
  output logic [SRC_W-1:0] vector_src_out,
  output logic push_valid_out,
  output logic [7:0] push_byte_out,
  output logic pop_pc_out,
  output logic [NUM_LEVELS-1:0] in_progress_out
);
  call_state_t state;
  logic sample_now;
  logic poll_now;
  logic [NUM_SRC-1:0] flag;
  logic reload_flag;
  logic [NUM_SRC-1:0] sampled;
  logic [1:0] ext_fall;
  logic ext3_edge;
  logic ext3_rise;
  logic ext3_fall;
  logic [2:0] ext_rise;
  logic reload_fall;
  logic [NUM_SRC-1:0] req_live;
  logic found;
  logic [SRC_W-1:0] win_src;
  logic [LEVEL_W-1:0] win_level;
  logic [NUM_LEVELS-1:0] in_prog;
  logic [LEVEL_W-1:0] top_level;
  logic any_prog;
  logic hold_one;
  logic blocked;
  logic take;
  logic take_wakeup;
  logic [NUM_SRC-1:0] ack_clear;
  logic [VEC_W-1:0] saved_pc;
  logic [SRC_W-1:0] win_src_q;

  // One machine cycle is a fixed number of steps; phase sequence from core
  assign sample_now = (phase_state_in == 3'(SAMPLE_STATE));
  assign poll_now = insn_last_cycle_in && (state == ST_RUN)
                    && (phase_state_in == 3'(STEPS_PER_CYCLE - 1));

  // Pins are sampled once a machine cycle, so 's hold time is assumed
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ext01
      ext_edge_detect #(.FALLING(1'b1)) u_fall (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .sample_in(sample_now),
        .pin_in(ext_request_pin_in[gi]),
        .edge_out(ext_fall[gi])
      );
    end
    for (gi = 0; gi < 3; gi++) begin : g_ext456
      ext_edge_detect #(.FALLING(1'b0)) u_rise (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .sample_in(sample_now),
        .pin_in(ext_high_pin_in[gi]),
        .edge_out(ext_rise[gi])
      );
    end
  endgenerate

  ext_edge_detect #(.FALLING(1'b1)) u_ext3_fall (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .sample_in(sample_now),
    .pin_in(ext_three_pin_in),
    .edge_out(ext3_fall)
  );

  ext_edge_detect #(.FALLING(1'b0)) u_ext3_rise (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .sample_in(sample_now),
    .pin_in(ext_three_pin_in),
    .edge_out(ext3_rise)
  );

  ext_edge_detect #(.FALLING(1'b1)) u_reload (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .sample_in(sample_now),
    .pin_in(reload_trigger_pin_in),
    .edge_out(reload_fall)
  );

  assign ext3_edge = ext_three_rising_in ? ext3_rise : ext3_fall;

  // Flags the hardware clears on vectoring; timer 2, serial, ADC stay set
  always_comb begin
    ack_clear = '0;
    if (state == ST_CALL1) begin
      ack_clear[win_src_q] = 1'b1;
    end
    ack_clear[SRC_ADC] = 1'b0;
    ack_clear[SRC_SERIAL] = 1'b0;
    ack_clear[SRC_TIMER2] = 1'b0;
  end

  // Hardware set beats a same-cycle software or vectoring clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flag <= '0;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        flag[i] <= (flag[i] && !flag_clear_in[i] && !ack_clear[i])
                   || flag_set_in[i];
      end
      for (int i = 0; i < 2; i++) begin
        if (!ext_trigger_type_bit_in[i]) begin
          flag[2 * i * 2] <= !ext_request_pin_in[i];
        end else if (ext_fall[i]) begin
          flag[2 * i * 2] <= 1'b1;
        end
      end
      if (ext3_edge) begin
        flag[SRC_EXT3] <= 1'b1;
      end
      if (ext_rise[0]) begin
        flag[SRC_EXT4] <= 1'b1;
      end
      if (ext_rise[1]) begin
        flag[SRC_EXT5] <= 1'b1;
      end
      if (ext_rise[2]) begin
        flag[SRC_EXT6] <= 1'b1;
      end
      if (timer0_overflow_in) begin
        flag[SRC_TIMER0] <= 1'b1;
      end
      if (timer1_overflow_in) begin
        flag[SRC_TIMER1] <= 1'b1;
      end
      if (can_sw_request_in) begin
        flag[SRC_CAN_SW] <= 1'b1;
      end
      flag[SRC_ADC] <= conversion_done_flag_in;
      flag[SRC_SERIAL] <= serial_rx_tx_flags_in;
      flag[SRC_TIMER2] <= timer_two_overflow_flag_in || reload_flag;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reload_flag <= 1'b0;
    end else if (reload_fall && ext_reload_enable_in) begin
      reload_flag <= 1'b1;
    end else if (reload_flag_clear_in) begin
      reload_flag <= 1'b0;
    end
  end

  // Snapshot once a machine cycle; poll reads only this snapshot
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sampled <= '0;
    end else if (sample_now) begin
      sampled <= flag;
    end
  end

  assign req_live = global_enable_in ? (sampled & source_enable_in) : '0;

  prio_select u_sel (
    .req_in(req_live),
    .prio_low_in(priority_low_bits_reg_in),
    .prio_high_in(priority_high_bits_reg_in),
    .found_out(found),
    .src_out(win_src),
    .level_out(win_level)
  );

  always_comb begin
    any_prog = |in_prog;
    top_level = '0;
    for (int l = 0; l < NUM_LEVELS; l++) begin
      if (in_prog[l]) begin
        top_level = LEVEL_W'(l);
      end
    end
  end

  // Equal level blocks too, so level 3 routines are never preempted by a source
  assign blocked = (any_prog && win_level <= top_level)
                   || !poll_now
                   || hold_one;
  assign take = found && !blocked;
  assign take_wakeup = wakeup_request_in && poll_now && !hold_one;

  // The poll ending a return or irq register write is refused, so the
  // next instruction always runs before any call
  assign hold_one = insn_is_return_from_interrupt_in || insn_writes_irq_regs_in;

  // Two machine cycles of call: push low then high byte of the return address
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_RUN;
      win_src_q <= '0;
      saved_pc <= '0;
      vector_out <= '0;
      long_call_out <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          if (take || take_wakeup) begin
            state <= ST_CALL1;
            win_src_q <= win_src;
            saved_pc <= pc_in;
            vector_out <= take ? VEC_TABLE[win_src] : VEC_WAKEUP;
            long_call_out <= 1'b1;
          end
        end
        ST_CALL1: begin
          if (phase_state_in == 3'(STEPS_PER_CYCLE - 1)) begin
            state <= ST_CALL2;
          end
        end
        ST_CALL2: begin
          if (phase_state_in == 3'(STEPS_PER_CYCLE - 1)) begin
            state <= ST_RUN;
            long_call_out <= 1'b0;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      push_valid_out <= 1'b0;
      push_byte_out <= '0;
    end else begin
      // Program counter only; the status word is left to software
      push_valid_out <= (state != ST_RUN)
                        && (phase_state_in == 3'h0);
      push_byte_out <= (state == ST_CALL1) ? saved_pc[7:0] : saved_pc[15:8];
    end
  end

  // Set on vectoring; only return-from-interrupt clears, plain return ignored
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      in_prog <= '0;
      pop_pc_out <= 1'b0;
    end else begin
      pop_pc_out <= insn_is_return_from_interrupt_in && insn_last_cycle_in
                    && (phase_state_in == 3'(STEPS_PER_CYCLE - 1));
      if (state == ST_RUN && take) begin
        in_prog[win_level] <= 1'b1;
      end else if (pop_pc_out && !insn_is_ret_in) begin
        in_prog[top_level] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      vector_src_out <= '0;
      call_cycle_out <= '0;
    end else begin
      vector_src_out <= win_src_q;
      call_cycle_out <= {state == ST_CALL2, state == ST_CALL1};
    end
  end

  assign flag_out = flag;
  assign timer_reload_ext_flag_out = reload_flag;
  assign in_progress_out = in_prog;
endmodule

// File: sim/irq_checker.sv
module irq_checker
  import irq_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] phase_state_in,
  input wire logic insn_last_cycle_in,
  input wire logic insn_is_return_from_interrupt_in,
  input wire logic insn_writes_irq_regs_in,
  input wire logic [NUM_GROUPS-1:0] priority_low_bits_reg_in,
  input wire logic [NUM_GROUPS-1:0] priority_high_bits_reg_in,
  input wire logic [VEC_W-1:0] pc_in,
  input wire logic long_call_out,
  input wire logic [VEC_W-1:0] vector_out,
  input wire logic [SRC_W-1:0] vector_src_out,
  input wire logic push_valid_out,
  input wire logic [7:0] push_byte_out,
  input wire logic pop_pc_out,
  input wire logic [NUM_LEVELS-1:0] in_progress_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CALL_LEN = CALL_CYCLES * STEPS_PER_CYCLE - 1;
  logic [3:0] len;
  logic [2:0] grp;
  logic [LEVEL_W-1:0] lvl;
  assign grp = vector_src_out[3:1];
  assign lvl = {priority_high_bits_reg_in[grp], priority_low_bits_reg_in[grp]};
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Counts clocks of the call so its length can be checked at the fall
  always_ff @(posedge clk_in) begin
    if (rst_in || !long_call_out) begin
      len <= 4'h0;
    end else begin
      len <= len + 4'h1;
    end
  end
  a_reset_quiet: assert property (
    $fell(rst_in) |-> !long_call_out && in_progress_out == 4'h0)
    else $error("outputs not cleared by reset");
  a_call_on_last: assert property (
    $rose(long_call_out) |->
      $past(phase_state_in) == 3'h5 && $past(insn_last_cycle_in))
    else $error("call not at end of instruction poll");
  a_call_not_return_from_interrupt: assert property (
    $rose(long_call_out) |->
      !$past(insn_is_return_from_interrupt_in) && !$past(insn_writes_irq_regs_in))
    else $error("call after return or register write");
  a_call_length: assert property (
    $fell(long_call_out) |-> $past(len) == CALL_LEN)
    else $error("call length wrong");
  // Source number settles one clock after the call starts
  a_vector_match: assert property (
    $rose(long_call_out) |=>
      vector_out == VEC_TABLE[vector_src_out] || vector_out == VEC_WAKEUP)
    else $error("vector does not match source");
  a_level_block: assert property (
    $rose(long_call_out) && vector_out != VEC_WAKEUP |=>
      ($past(in_progress_out, 2) >> lvl) == 4'h0)
    else $error("call at blocked level");
  a_level_marked: assert property (
    $rose(long_call_out) && vector_out != VEC_WAKEUP |->
      ##[0:12] in_progress_out[lvl])
    else $error("level not marked in progress");
  a_push_low: assert property (
    $rose(long_call_out) |->
      ##[0:12] (push_valid_out && push_byte_out == pc_in[7:0]))
    else $error("low return byte not pushed");
  a_push_high: assert property (
    push_valid_out && push_byte_out == pc_in[7:0] |->
      ##[1:12] (push_valid_out && push_byte_out == pc_in[15:8]))
    else $error("high return byte not pushed");
  a_pop_pulse: assert property (
    pop_pc_out |=> !pop_pc_out)
    else $error("pop longer than one cycle");
  c_call: cover property ($rose(long_call_out));
  c_push: cover property (push_valid_out);
  c_pop: cover property (pop_pc_out);
endmodule

bind four_level_interrupt_controller irq_checker chk (
  .clk_in, .rst_in, .phase_state_in, .insn_last_cycle_in,
  .insn_is_return_from_interrupt_in, .insn_writes_irq_regs_in, .priority_low_bits_reg_in,
  .priority_high_bits_reg_in, .pc_in, .long_call_out, .vector_out,
  .vector_src_out, .push_valid_out, .push_byte_out, .pop_pc_out,
  .in_progress_out
);

// File: sim/cpu_model.sv
module cpu_model (
  input wire logic clk_in,
  input wire logic hold_in,
  output logic [2:0] phase_out,
  output logic last_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 1;
  initial begin
    phase_out = 3'h0;
    last_out = 1'b1;
  end
  // Instructions last one to four machine cycles; none run during a call
  always @(negedge clk_in) begin
    if (phase_out != 3'h5) begin
      phase_out <= phase_out + 3'h1;
    end else begin
      phase_out <= 3'h0;
      if (hold_in) begin
        last_out <= 1'b0;
      end else begin
        cnt = (cnt > 1) ? cnt - 1 : $urandom_range(4, 1);
        last_out <= (cnt == 1);
      end
    end
  end
endmodule

// File: sim/tb.sv
module tb;
  import irq_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic return_from_interrupt = 1'b0, ret = 1'b0, wr = 1'b0, gen = 1'b0, t0 = 1'b0;
  logic t2 = 1'b0, ser = 1'b0, adc = 1'b0, rpin = 1'b1, renb = 1'b0;
  logic lc, pv, pop, rflag, last;
  logic [1:0] trig = 2'h3, xpin = 2'h3, cc;
  logic [2:0] hpin = 3'h0, ph;
  logic [5:0] plo = 6'h00, phi = 6'h00;
  logic [11:0] en = 12'h000, fset = 12'h000, fclr = 12'h000, flag, m;
  logic [15:0] pc = 16'h00FF, vec;
  logic [3:0] vsrc, inp;
  logic [7:0] pb, b;
  int n_errors = 0;
  int checks = 0;
  always #5 clk_in = ~clk_in;
  cpu_model core (.clk_in, .hold_in(lc), .phase_out(ph), .last_out(last));
  four_level_interrupt_controller uut (
    .clk_in, .rst_in, .phase_state_in(ph), .insn_last_cycle_in(last),
    .insn_is_return_from_interrupt_in(return_from_interrupt), .insn_is_ret_in(ret),
    .insn_writes_irq_regs_in(wr), .global_enable_in(gen),
    .source_enable_in(en), .priority_low_bits_reg_in(plo),
    .priority_high_bits_reg_in(phi), .ext_trigger_type_bit_in(trig),
    .ext_request_pin_in(xpin), .ext_three_pin_in(1'b1),
    .ext_three_rising_in(1'b0), .ext_high_pin_in(hpin),
    .reload_trigger_pin_in(rpin), .ext_reload_enable_in(renb),
    .timer0_overflow_in(t0), .timer1_overflow_in(t0),
    .timer_two_overflow_flag_in(t2), .serial_rx_tx_flags_in(ser),
    .conversion_done_flag_in(adc), .can_sw_request_in(1'b0),
    .wakeup_request_in(1'b0), .flag_set_in(fset), .flag_clear_in(fclr),
    .reload_flag_clear_in(fclr[10]), .pc_in(pc), .flag_out(flag),
    .timer_reload_ext_flag_out(rflag), .long_call_out(lc),
    .call_cycle_out(cc), .vector_out(vec), .vector_src_out(vsrc),
    .push_valid_out(pv), .push_byte_out(pb), .pop_pc_out(pop),
    .in_progress_out(inp)
  );
  task tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task done(input string t);
    $display("test %s done", t);
  endtask
  task end_of_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task setf(input logic [11:0] v);
    fset = v;
    tick(1);
    fset = 12'h000;
  endtask
  task clr;
    fclr = 12'hFFF;
    tick(1);
    fclr = 12'h000;
  endtask
  // Source number settles one clock after the call starts
  task wait_call;
    for (int i = 0; i < 200 && lc !== 1'b1; i++) @(negedge clk_in);
    chk("call_seen", 16'h1, 16'(lc));
    @(negedge clk_in);
  endtask
  // Holds the kind bits for exactly one instruction, boundary to boundary
  task insn(input logic [2:0] k);
    int i;
    for (i = 0; i < 200 && !(ph == 3'h5 && last); i++) @(negedge clk_in);
    {wr, ret, return_from_interrupt} = k;
    @(negedge clk_in);
    for (i = 0; i < 200 && !(ph == 3'h5 && last); i++) @(negedge clk_in);
    {wr, ret, return_from_interrupt} = 3'h0;
    @(negedge clk_in);
  endtask
  // Highest level wins; ascending index is the polling order
  function automatic logic [3:0] win(input logic [11:0] v);
    int bs = 0;
    int bl = -1;
    for (int s = 0; s < 12; s++) begin
      if (v[s] && int'({phi[s/2], plo[s/2]}) > bl) begin
        bs = s;
        bl = int'({phi[s/2], plo[s/2]});
      end
    end
    return 4'(bs);
  endfunction
  initial begin
    #300000;
    n_errors++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h0EFD88F0));
    tick(20);
    rst_in = 1'b0;
    tick(2);
    chk("in_progress", 16'h0, 16'(inp));
    chk("flags", 16'h0, 16'(flag));
    done("reset");
    hpin = 3'h7;
    tick(18);
    chk("ext_rise", 16'h7, 16'({flag[11], flag[9], flag[7]}));
    clr;
    hpin = 3'h0;
    tick(18);
    chk("ext_fall", 16'h0, 16'({flag[11], flag[9], flag[7]}));
    xpin = 2'h0;
    tick(18);
    chk("ext_edge", 16'h3, 16'({flag[4], flag[0]}));
    clr;
    trig = 2'h0;
    tick(18);
    chk("ext_level", 16'h3, 16'({flag[4], flag[0]}));
    xpin = 2'h3;
    tick(18);
    chk("ext_level_off", 16'h0, 16'({flag[4], flag[0]}));
    rpin = 1'b0;
    tick(18);
    chk("reload_off", 16'h0, 16'(rflag));
    renb = 1'b1;
    rpin = 1'b1;
    tick(18);
    rpin = 1'b0;
    tick(18);
    chk("reload_on", 16'h1, 16'(rflag));
    clr;
    done("pins");
    trig = 2'h3;
    gen = 1'b1;
    for (int s = 0; s < 12; s++) begin
      b = 8'($urandom);
      pc = {~b, b};
      en = 12'h001 << s;
      fset = en & 12'hAF9;
      t0 = en[2];
      {t2, ser, adc} = {en[10], en[8], en[1]};
      tick(1);
      fset = 12'h000;
      t0 = 1'b0;
      wait_call;
      chk("vector", VEC_TABLE[s], vec);
      chk("source", 16'(s), 16'(vsrc));
      tick(14);
      chk("flag_kept", 16'((en & 12'h502) != 0), 16'(flag[s]));
      {t2, ser, adc} = 3'h0;
      clr;
      insn(3'b001);
      tick(2);
      chk("in_progress", 16'h0, 16'(inp));
    end
    done("vectors");
    en = 12'hFFF;
    for (int r = 0; r < 10; r++) begin
      {phi, plo} = 12'($urandom);
      m = 12'($urandom) & 12'hAFD;
      if (m == 12'h000) m = 12'h080;
      setf(m);
      wait_call;
      chk("winner", 16'(win(m)), 16'(vsrc));
      tick(14);
      clr;
      insn(3'b100);
      insn(3'b001);
    end
    done("priority");
    {phi, plo} = 12'h002;
    setf(12'h001);
    wait_call;
    tick(14);
    setf(12'h004);
    wait_call;
    chk("preempt", 16'h2, 16'(vsrc));
    tick(14);
    chk("in_progress", 16'h3, 16'(inp));
    setf(12'h008);
    tick(80);
    chk("equal_held", 16'h0, 16'(lc));
    insn(3'b010);
    tick(30);
    chk("ret_held", 16'h3, 16'(inp));
    insn(3'b001);
    wait_call;
    chk("after_return_from_interrupt", 16'h3, 16'(vsrc));
    tick(14);
    setf(12'h010);
    clr;
    insn(3'b001);
    insn(3'b001);
    tick(40);
    chk("dropped", 16'h0, 16'(lc));
    chk("in_progress", 16'h0, 16'(inp));
    done("preempt");
    end_of_test;
  end
endmodule
